// ### rtl/card_bus_pkg.sv
// constants shared by both ends of the card host bus signalling
// assumes a single 40 MHz clock on both ends
package card_bus_pkg;
  localparam int unsigned data_width = 16;
  localparam int unsigned byte_width = 8;
  localparam int unsigned reg_addr_width = 3;
  localparam int unsigned even_lsb = 0;
  localparam int unsigned odd_lsb = 8;
  localparam int unsigned clk_period_ns = 25;
  localparam int unsigned strobe_ns = 75;
  localparam int unsigned strobe_cycles = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
  // two-flop synchronisers at each end plus the card's drive register
  localparam int unsigned round_trip_cycles = 5;
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [15:0] word_reset_value = 16'h0000;
  typedef enum logic [1:0] {
    mode_mem = 2'b00,
    mode_io = 2'b01,
    mode_ide = 2'b10
  } bus_mode_e;
endpackage

// ### rtl/card_bus_if.sv
// pin-level carrier between host controller and card
// resolves two-way pins from the drive enables of both ends
`timescale 1ns/1ps
`default_nettype none
interface card_bus_if;
  import card_bus_pkg::*;
  logic [15:0] d_host;
  logic d_host_oe;
  logic [15:0] d_card;
  logic d_card_oe;
  logic [15:0] d;
  logic [2:0] addr;
  logic a0;
  logic cs0_n;
  logic cs1_n;
  logic ce1_n;
  logic ce2_n;
  logic iord_n;
  logic iowr_n;
  logic dmack_n;
  logic dmarq_o;
  logic dmarq_oe;
  logic dmarq;
  logic inpack_n;
  logic spkr_n_o;
  logic spkr_oe;
  logic spkr_n;
  assign d = d_card_oe ? d_card : (d_host_oe ? d_host : word_reset_value);
  assign dmarq = dmarq_oe ? dmarq_o : 1'b0;
  assign spkr_n = spkr_oe ? spkr_n_o : 1'b1;
  modport card (
    input d, addr, a0, cs0_n, cs1_n, ce1_n, ce2_n, iord_n, iowr_n, dmack_n,
    output d_card, d_card_oe, dmarq_o, dmarq_oe, inpack_n, spkr_n_o, spkr_oe
  );
  modport host (
    input d, dmarq, inpack_n, spkr_n,
    output d_host, d_host_oe, addr, a0, cs0_n, cs1_n, ce1_n, ce2_n, iord_n, iowr_n, dmack_n
  );
endinterface
`default_nettype wire

// ### rtl/card_bus_device.sv
// What this block does
// - no audio: speaker line held negated
// - d0 even byte lsb, d8 odd
// - ide registers on d7..0, data 16 bits
// - input ack only on selected io read
// - request raised when data ready
// - hold request until ack, re-raise if more
// - request undriven when not selected
// - host keeps chip selects negated during dma
// - read strobe card-to-host, write host-to-card
// - cs0 task file, cs1 control registers
// - ce2 odd byte, ce1 by a0
// card end: decodes host strobes, drives data, input ack and dma request
// assumes host pins are asynchronous, so all are synchronised first
`timescale 1ns/1ps
`default_nettype none
module card_bus_device
  import card_bus_pkg::*;
#(
  parameter int unsigned dw = card_bus_pkg::data_width
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  card_bus_if.card bus,
  input wire card_bus_pkg::bus_mode_e mode,
  input wire logic selected,
  input wire logic dma_ready,
  input wire logic dma_more,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] data_rdata,
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_ctl,
  output logic [2:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic data_rd,
  output logic data_wr,
  output logic [15:0] data_wdata,
  output logic [1:0] data_lanes
);
  import card_bus_pkg::*;
  // lane logic is written for one 16-bit word only
  if (dw != data_width) begin : g_bad_width
    $error("card_bus_device: bus width must be 16");
  end
  localparam int unsigned n_sync = 10;
  logic [n_sync-1:0] raw;
  logic [n_sync-1:0] s1_q;
  logic [n_sync-1:0] s2_q;
  logic [n_sync-1:0] s3_q;
  logic [15:0] d1_q;
  logic [15:0] d2_q;
  logic [2:0] a1_q;
  logic [2:0] a2_q;
  assign raw = {bus.a0, bus.cs0_n, bus.cs1_n, bus.ce1_n, bus.ce2_n,
                bus.iord_n, bus.iowr_n, bus.dmack_n, 2'b00};
  genvar gi;
  generate
    for (gi = 0; gi < n_sync; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
        end else if (clk_en) begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      d1_q <= word_reset_value;
      d2_q <= word_reset_value;
      a1_q <= 3'h0;
      a2_q <= 3'h0;
    end else if (clk_en) begin
      d1_q <= bus.d;
      d2_q <= d1_q;
      a1_q <= bus.addr;
      a2_q <= a1_q;
    end
  end
  logic a0_s, cs0_s, cs1_s, ce1_s, ce2_s, rd_s, wr_s, ack_s, rd_p, wr_p;
  assign a0_s = s2_q[9];
  assign cs0_s = !s2_q[8];
  assign cs1_s = !s2_q[7];
  assign ce1_s = !s2_q[6];
  assign ce2_s = !s2_q[5];
  assign rd_s = !s2_q[4];
  assign wr_s = !s2_q[3];
  assign ack_s = !s2_q[2];
  assign rd_p = !s3_q[4];
  assign wr_p = !s3_q[3];
  logic ide;
  logic ide_reg;
  logic pc_sel;
  logic [1:0] lanes;
  assign ide = (mode == mode_ide);
  assign ide_reg = ide && (cs0_s || cs1_s) && !ack_s;
  assign pc_sel = !ide && (ce1_s || ce2_s);
  always_comb begin
    lanes = 2'b00;
    if (ce1_s && ce2_s) lanes = 2'b11;
    else if (ce2_s) lanes = 2'b10;
    else if (ce1_s) lanes = a0_s ? 2'b10 : 2'b01;
  end
  logic dma_rd, dma_wr;
  assign dma_rd = ide && ack_s && rd_s;
  assign dma_wr = ide && ack_s && wr_p;
  logic rd_rise, wr_fall;
  assign rd_rise = (rd_s && !rd_p);
  assign wr_fall = (!wr_s && wr_p);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.d_card <= word_reset_value;
      bus.d_card_oe <= 1'b0;
    end else if (clk_en) begin
      bus.d_card_oe <= rd_s && selected && (ide_reg || dma_rd || pc_sel);
      if (ide_reg) bus.d_card <= {reg_reset_value, reg_rdata};
      else if (dma_rd || (pc_sel && lanes == 2'b11) || ide) bus.d_card <= data_rdata;
      else if (lanes == 2'b10 && !ce2_s) bus.d_card <= {reg_reset_value, data_rdata[odd_lsb +: byte_width]};
      else bus.d_card <= data_rdata;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) bus.inpack_n <= 1'b1;
    else if (clk_en) bus.inpack_n <= !(mode == mode_io && pc_sel && selected && rd_s);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.spkr_n_o <= 1'b1;
      bus.spkr_oe <= 1'b0;
    end else if (clk_en) begin
      bus.spkr_n_o <= 1'b1;
      bus.spkr_oe <= !ide;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      reg_ctl <= 1'b0;
      reg_addr <= 3'h0;
      reg_wdata <= reg_reset_value;
    end else if (clk_en) begin
      reg_rd <= selected && (ide_reg || pc_sel) && rd_rise;
      reg_wr <= selected && (ide_reg || pc_sel) && wr_fall;
      reg_ctl <= cs1_s;
      reg_addr <= a2_q;
      reg_wdata <= (pc_sel && lanes == 2'b10) ? d2_q[odd_lsb +: byte_width] : d2_q[even_lsb +: byte_width];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      data_wdata <= word_reset_value;
      data_lanes <= 2'b00;
    end else if (clk_en) begin
      data_rd <= dma_rd && rd_rise;
      data_wr <= dma_wr && wr_fall;
      data_wdata <= d2_q;
      data_lanes <= (ide && ack_s) ? 2'b11 : lanes;
    end
  end
  logic req_q;
  logic acked_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (clk_en) begin
      if (!req_q && !acked_q && dma_ready) req_q <= 1'b1;
      else if (req_q && ack_s) begin
        req_q <= 1'b0;
        acked_q <= 1'b1;
      end else if (acked_q && !ack_s) begin
        acked_q <= 1'b0;
        req_q <= dma_more && dma_ready;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.dmarq_o <= 1'b0;
      bus.dmarq_oe <= 1'b0;
    end else if (clk_en) begin
      bus.dmarq_o <= req_q && ide;
      bus.dmarq_oe <= selected && ide;
    end
  end
endmodule // card_bus_device
`default_nettype wire

// ### rtl/card_bus_host.sv
// host end: drives strobes and chip selects, answers the card's dma request
// assumes the card signals are asynchronous and synchronises them
`timescale 1ns/1ps
`default_nettype none
module card_bus_host
  import card_bus_pkg::*;
#(
  parameter int unsigned hold = card_bus_pkg::strobe_cycles
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  card_bus_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_ctl,
  input wire logic req_dma,
  input wire logic [2:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic dma_pending
);
  import card_bus_pkg::*;
  if (hold < 1 || hold > 255 - round_trip_cycles) begin : g_bad_hold
    $error("card_bus_host: hold out of range");
  end
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_strobe = 2'b01,
    st_end = 2'b10
  } host_st_e;
  host_st_e st_q;
  logic [7:0] cnt_q;
  logic rq1_q, rq2_q;
  logic [15:0] d1_q, d2_q;
  logic dma_q, wr_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rq1_q <= 1'b0;
      rq2_q <= 1'b0;
      d1_q <= word_reset_value;
      d2_q <= word_reset_value;
    end else if (clk_en) begin
      rq1_q <= bus.dmarq;
      rq2_q <= rq1_q;
      d1_q <= bus.d;
      d2_q <= d1_q;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) dma_pending <= 1'b0;
    else if (clk_en) dma_pending <= rq2_q;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= st_idle;
      cnt_q <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= word_reset_value;
      dma_q <= 1'b0;
      wr_q <= 1'b0;
      bus.cs0_n <= 1'b1;
      bus.cs1_n <= 1'b1;
      bus.ce1_n <= 1'b1;
      bus.ce2_n <= 1'b1;
      bus.a0 <= 1'b0;
      bus.addr <= 3'h0;
      bus.iord_n <= 1'b1;
      bus.iowr_n <= 1'b1;
      bus.dmack_n <= 1'b1;
      bus.d_host <= word_reset_value;
      bus.d_host_oe <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (st_q)
        st_idle: begin
          if (req && (!req_dma || rq2_q)) begin
            busy <= 1'b1;
            dma_q <= req_dma;
            wr_q <= req_write;
            bus.addr <= req_addr;
            bus.cs0_n <= req_dma || req_ctl;
            bus.cs1_n <= req_dma || !req_ctl;
            // byte access on the even enable, a0 held low
            bus.ce1_n <= req_dma;
            bus.dmack_n <= !req_dma;
            // register writes on low lanes only
            bus.d_host <= req_dma ? req_wdata : {reg_reset_value, req_wdata[7:0]};
            bus.d_host_oe <= req_write;
            cnt_q <= 8'h00;
            st_q <= st_strobe;
          end
        end
        st_strobe: begin
          bus.iord_n <= wr_q;
          bus.iowr_n <= !wr_q;
          cnt_q <= cnt_q + 8'h01;
          // strobe stands until the card's answer has crossed both synchronisers
          if (cnt_q == 8'(hold + round_trip_cycles)) begin
            rdata <= dma_q ? d2_q : {reg_reset_value, d2_q[7:0]};
            bus.iord_n <= 1'b1;
            bus.iowr_n <= 1'b1;
            st_q <= st_end;
          end
        end
        st_end: begin
          if (!dma_q || !rq2_q) begin
            bus.dmack_n <= 1'b1;
            bus.cs0_n <= 1'b1;
            bus.cs1_n <= 1'b1;
            bus.ce1_n <= 1'b1;
            bus.d_host_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            st_q <= st_idle;
          end
        end
        default: st_q <= st_idle;
      endcase
    end
  end
endmodule // card_bus_host
`default_nettype wire

// ### testbench/card_bus_checker.sv
// checker: pin-level rules on the card host bus
// assumes it is instantiated beside the interface, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module card_bus_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic dmarq,
  input wire logic dmack_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic iord_n,
  input wire logic inpack_n,
  input wire logic d_card_oe,
  input wire logic spkr_n
);
  // ages saturate so long idle stretches never wrap into a false match
  logic [3:0] rq_age_q;
  logic [3:0] ack_age_q;
  logic [3:0] rd_age_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rq_age_q <= 4'hf;
    else if (dmarq) rq_age_q <= 4'h0;
    else if (rq_age_q != 4'hf) rq_age_q <= rq_age_q + 4'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ack_age_q <= 4'hf;
    else if (!dmack_n) ack_age_q <= 4'h0;
    else if (ack_age_q != 4'hf) ack_age_q <= ack_age_q + 4'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rd_age_q <= 4'hf;
    else if (!iord_n) rd_age_q <= 4'h0;
    else if (rd_age_q != 4'hf) rd_age_q <= rd_age_q + 4'h1;
  end
  chk_spkr_negated: assert property (spkr_n)
    else $error("speaker line asserted");
  chk_dma_no_select: assert property (!dmack_n |-> cs0_n && cs1_n)
    else $error("chip select during dma ack");
  // the slack of 6 covers the card's synchroniser delay on the ack
  chk_req_held: assert property (dmarq && ack_age_q > 4'h6 |=> dmarq)
    else $error("dma request dropped without ack");
  chk_req_drops: assert property ($fell(dmack_n) |-> ##[1:12] !dmarq)
    else $error("dma request kept after ack");
  chk_ack_after_req: assert property ($fell(dmack_n) |-> rq_age_q < 4'h8)
    else $error("dma ack without request");
  chk_req_after_reset: assert property ($rose(reset_n) |-> !dmarq [*2])
    else $error("dma request right after reset");
  chk_inpack_read: assert property (!inpack_n |-> rd_age_q < 4'h6)
    else $error("input ack outside read");
  chk_read_drive: assert property (d_card_oe |-> rd_age_q < 4'h6)
    else $error("card drives data outside read");
endmodule // card_bus_checker
`default_nettype wire

// ### testbench/card_host_bus_dma_signals_bench.sv
// bench: host end and card end joined by the bus interface
// assumes hold of 1 and a 40 MHz clock; inputs move 2 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module card_host_bus_dma_signals_bench;
  import card_bus_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  bus_mode_e mode = mode_ide;
  logic selected = 1'b1, dma_ready = 1'b0, dma_more = 1'b0;
  logic [7:0] reg_rdata = 8'h00, reg_wdata, cap_wdata;
  logic [15:0] data_rdata = 16'h0000, data_wdata, rdata, req_wdata = 16'h0000, cap_data, cap_d;
  logic reg_rd, reg_wr, reg_ctl, data_rd, data_wr, busy, done, dma_pending, cap_ctl;
  logic [2:0] reg_addr, cap_addr, req_addr = 3'h0;
  logic [1:0] data_lanes, cap_lanes, cap_reg_lanes;
  logic req = 1'b0, req_write = 1'b0, req_ctl = 1'b0, req_dma = 1'b0;
  int n_fail = 0, n_tests = 0, n_inpack = 0, cycles = 0, n_rd = 0, n_drd = 0;
  card_bus_if bus();
  card_bus_device u_card_bus_device (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus), .mode(mode),
    .selected(selected), .dma_ready(dma_ready), .dma_more(dma_more), .reg_rdata(reg_rdata),
    .data_rdata(data_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ctl(reg_ctl), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_lanes(data_lanes));
  card_bus_host #(.hold(1)) u_card_bus_host (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .bus(bus),
    .req(req), .req_write(req_write), .req_ctl(req_ctl), .req_dma(req_dma), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .dma_pending(dma_pending));
  card_bus_checker u_card_bus_checker (.clk(clk), .reset_n(reset_n), .dmarq(bus.dmarq),
    .dmack_n(bus.dmack_n), .cs0_n(bus.cs0_n), .cs1_n(bus.cs1_n), .iord_n(bus.iord_n),
    .inpack_n(bus.inpack_n), .d_card_oe(bus.d_card_oe), .spkr_n(bus.spkr_n));
  always #12.5 clk = ~clk;
  // capture one-cycle pulses so they can be compared once the access settles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reg_wr === 1'b1) begin
      cap_addr <= reg_addr;
      cap_wdata <= reg_wdata;
      cap_ctl <= reg_ctl;
      cap_reg_lanes <= data_lanes;
    end
    if (reg_rd === 1'b1) n_rd <= n_rd + 1;
    if (data_rd === 1'b1) n_drd <= n_drd + 1;
    if (data_wr === 1'b1) begin
      cap_data <= data_wdata;
      cap_lanes <= data_lanes;
    end
    if (bus.inpack_n === 1'b0) n_inpack <= n_inpack + 1;
    if (bus.d_card_oe === 1'b1 && bus.dmack_n === 1'b0) cap_d <= bus.d;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  // req stays up until the host shows busy, so it is taken exactly once
  task automatic do_op(input logic wr, input logic ctl, input logic dma, input logic [2:0] a,
      input logic [15:0] wd);
    int i;
    i = 0;
    {req_write, req_ctl, req_dma, req_addr, req_wdata, req} = {wr, ctl, dma, a, wd, 1'b1};
    while (busy !== 1'b1 && i < 50) begin
      tick();
      i++;
    end
    req = 1'b0;
    while (done !== 1'b1 && i < 50) begin
      tick();
      i++;
    end
    chk1(done, 1'b1);
    repeat (6) tick();
  endtask
  task automatic wait_pending();
    int i;
    for (i = 0; i < 50 && dma_pending !== 1'b1; i++) tick();
    chk1(dma_pending, 1'b1);
  endtask
  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #2 reset_n = 1'b1;
    tick();
    tick();
    chk1(bus.dmarq, 1'b0);
    do_op(1'b1, 1'b0, 1'b0, 3'h5, 16'ha55a);
    chk16({8'h00, cap_wdata}, 16'h005a);
    chk16({13'h0000, cap_addr}, 16'h0005);
    chk1(cap_ctl, 1'b0);
    do_op(1'b1, 1'b1, 1'b0, 3'h6, 16'h1234);
    chk1(cap_ctl, 1'b1);
    reg_rdata = 8'hc3;
    do_op(1'b0, 1'b0, 1'b0, 3'h7, 16'h0000);
    chk16({8'h00, rdata[7:0]}, 16'h00c3);
    chk16(16'(n_rd), 16'h0001);
    data_rdata = 16'h1234;
    {dma_more, dma_ready} = 2'b11;
    wait_pending();
    do_op(1'b0, 1'b0, 1'b1, 3'h0, 16'h0000);
    chk16(rdata, 16'h1234);
    chk16(cap_d, 16'h1234);
    chk16(16'(n_drd), 16'h0001);
    wait_pending();
    // ready falls before the ack: the request must still be held for it
    {dma_more, dma_ready} = 2'b00;
    do_op(1'b1, 1'b0, 1'b1, 3'h0, 16'hbeef);
    chk16(cap_data, 16'hbeef);
    chk16({14'h0000, cap_lanes}, 16'h0003);
    repeat (10) tick();
    chk1(bus.dmarq, 1'b0);
    selected = 1'b0;
    dma_ready = 1'b1;
    repeat (10) tick();
    chk1(bus.dmarq_oe, 1'b0);
    chk1(dma_pending, 1'b0);
    {dma_ready, selected} = 2'b01;
    mode = mode_io;
    n_inpack = 0;
    do_op(1'b0, 1'b0, 1'b0, 3'h1, 16'h0000);
    chk1(n_inpack != 0, 1'b1);
    n_inpack = 0;
    do_op(1'b1, 1'b0, 1'b0, 3'h1, 16'h00a5);
    chk1(n_inpack == 0, 1'b1);
    chk16({8'h00, cap_wdata}, 16'h00a5);
    chk16({14'h0000, cap_reg_lanes}, 16'h0001);
    chk1(bus.spkr_n, 1'b1);
    chk16({14'h0000, bus.spkr_oe, bus.spkr_n_o}, 16'h0003);
    // back to ide so the request path is live across the second reset
    mode = mode_ide;
    dma_ready = 1'b1;
    reset_n = 1'b0;
    tick();
    reset_n = 1'b1;
    tick();
    chk1(bus.dmarq, 1'b0);
    summarize();
  end
endmodule // card_host_bus_dma_signals_bench
`default_nettype wire
